// ==== common/uif_pkg.sv ====
package uif_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_STATUS_SET = 4'h1;
  localparam logic [3:0] ADDR_STATUS_EN = 4'h2;
  localparam logic [3:0] ADDR_ERROR_FLAGS = 4'h3;
  localparam logic [3:0] ADDR_ERROR_SET = 4'h4;
  localparam logic [3:0] ADDR_ERROR_EN = 4'h5;
  localparam logic [3:0] ADDR_CONTROL = 4'h6;

  // Status flag positions that this block drives itself
  localparam int unsigned ST_ERR_BIT = 1;
  localparam int unsigned ST_ACT_BIT = 2;
  localparam int unsigned ST_IDLE_BIT = 4;
  // Status bits fed straight from the engine event inputs
  localparam logic [7:0] ST_ENGINE_MASK = 8'hE9;

  // Control register fields
  localparam int unsigned CTL_PULLUP_BIT = 0;
  localparam int unsigned CTL_SUSPEND_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Timing
  localparam int unsigned CLK_FREQ_KHZ = 25000;
  localparam int unsigned IDLE_TIME_US = 3000;
  localparam int unsigned IDLE_CYCLES =
    (IDLE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned WAKE_SYNC_CYCLES = 4;
  localparam int unsigned WAKE_CNT_W = 3;

  // Wake-up tracker states
  typedef enum logic [1:0] {
    WK_RUN,
    WK_SUSP,
    WK_LOCK,
    WK_SYNC
  } uif_wake_t;

endpackage

// ==== common/uif_flag_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Sticky flag bank connection: set and clear requests in, flags out
interface uif_flag_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] hw_set;
  logic [W-1:0] sw_set;
  logic [W-1:0] sw_clr;
  logic [W-1:0] flags;

  modport bank (
    input hw_set,
    input sw_set,
    input sw_clr,
    output flags
  );

  modport ctl (
    output hw_set,
    output sw_set,
    output sw_clr,
    input flags
  );
endinterface

`default_nettype wire

// ==== core/uif_flag_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

module uif_flag_bank #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Set, clear and flag view
  uif_flag_if.bank fl
);

  logic [W-1:0] flags_q;

  // One sticky bit per flag; a set in the clearing cycle wins
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
        flags_q[i] <= 1'b0;
      else if (fl.hw_set[i] || fl.sw_set[i])
        flags_q[i] <= 1'b1;
      else if (fl.sw_clr[i])
        flags_q[i] <= 1'b0;
    end
  end

  assign fl.flags = flags_q;

  AST_SET_WINS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (fl.hw_set & fl.sw_clr) != '0
    |=> (fl.flags & $past(fl.hw_set)) == $past(fl.hw_set))
    else $error("Hardware set lost against software clear");

  AST_STICKY: assert property (
    @(posedge i_clk) disable iff (i_rst)
    fl.flags != '0
    |=> (fl.flags & $past(fl.flags & ~fl.sw_clr))
        == $past(fl.flags & ~fl.sw_clr))
    else $error("Flag dropped without a software clear");

endmodule

`default_nettype wire

// ==== core/uif_idle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module uif_idle_timer #(
  parameter int unsigned LIMIT = 75000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus traffic seen this cycle
  input wire logic i_traffic,
  // One-cycle pulse after LIMIT quiet cycles
  output logic o_idle_pulse
);

  localparam int unsigned CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] cnt_q;
  logic idle_pulse_q;

  // Quiet counter saturates so one silence gives one pulse
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt_q <= '0;
    else if (i_traffic)
      cnt_q <= '0;
    else if (cnt_q != CNT_MAX)
      cnt_q <= cnt_q + CNT_ONE;
  end

  // Pulse on the edge where the count reaches its limit
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      idle_pulse_q <= 1'b0;
    else
      idle_pulse_q <= !i_traffic && (cnt_q == CNT_MAX - CNT_ONE);
  end

  assign o_idle_pulse = idle_pulse_q;

  AST_IDLE_AT_LIMIT: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_idle_pulse |-> (cnt_q == CNT_MAX) && $past(!i_traffic))
    else $error("Idle pulse before the quiet time elapsed");

  AST_IDLE_ONCE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_idle_pulse |=> !o_idle_pulse)
    else $error("Idle pulse repeated in one silence");

endmodule

`default_nettype wire

// ==== core/uif_irq_funnel.sv ====
// Summary of operation
// - All USB interrupt sources funnel into one summary request output.
// - Summary request is the OR of status flags gated by status enables.
// - Status enables gate only the summary; flags always set for polling.
// - Enabled error flags are ORed into the error summary status flag.
// - Error summary sets when any enabled error flag is set.
// - Error flags set in the cycle the error condition arrives.
// - Flags stay set until software clears them; no hardware clear.
// - Software may set any flag; it acts like a hardware set.
// - Bus-activity clear ignored while suspended and until wake sync ends.
// - Bus-activity flag sets once per resume, rearmed only by bus idle.
// - Bus-idle flag sets after more than 3 ms without traffic.
// - After suspend ends, logic waits for clock lock before syncing.
// - Pull-up stays enabled through suspend.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module uif_irq_funnel #(
  parameter int unsigned IDLE_CYCLES = uif_pkg::IDLE_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [uif_pkg::ADDR_W-1:0] i_addr,
  input wire logic [uif_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [uif_pkg::DATA_W-1:0] o_rdata,
  // Serial interface engine events
  input wire logic [uif_pkg::DATA_W-1:0] i_status_evt,
  input wire logic [uif_pkg::DATA_W-1:0] i_error_evt,
  input wire logic i_bus_traffic,
  // Clock source lock, asynchronous
  input wire logic i_pll_locked,
  // Towards the core and the transceiver
  output logic o_usb_summary_irq_flag,
  output logic o_suspend_request_bit,
  output logic o_pullup_en
);

  localparam int unsigned DW = uif_pkg::DATA_W;
  localparam logic [uif_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
    uif_pkg::WAKE_CNT_W'(uif_pkg::WAKE_SYNC_CYCLES - 1);
  localparam logic [uif_pkg::WAKE_CNT_W-1:0] WAKE_ONE =
    uif_pkg::WAKE_CNT_W'(1);

  // Address match, used by every decode below
  function automatic logic hit(
    input logic [uif_pkg::ADDR_W-1:0] addr,
    input logic [uif_pkg::ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction

  uif_flag_if #(.W(DW)) status_if ();
  uif_flag_if #(.W(DW)) error_if ();

  logic [DW-1:0] status_en_q;
  logic [DW-1:0] error_en_q;
  logic suspend_q;
  logic pullup_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic summary_q;
  logic armed_q;
  logic pll_meta_q;
  logic pll_sync_q;
  uif_pkg::uif_wake_t wake_q;
  logic [uif_pkg::WAKE_CNT_W-1:0] wake_cnt_q;
  logic idle_pulse;
  logic act_set;
  logic err_any;
  logic clr_block;
  logic [DW-1:0] st_hw;
  logic [DW-1:0] st_clr_mask;
  logic wr_status_clr;

  // Sticky flag banks for the two levels
  uif_flag_bank #(.W(DW)) u_status_bank (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fl(status_if.bank)
  );

  uif_flag_bank #(.W(DW)) u_error_bank (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fl(error_if.bank)
  );

  // Silence detector for the host's suspend signalling
  uif_idle_timer #(.LIMIT(IDLE_CYCLES)) u_idle (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_traffic(i_bus_traffic),
    .o_idle_pulse(idle_pulse)
  );

  // Lock input comes from another clock domain
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pll_meta_q <= 1'b0;
      pll_sync_q <= 1'b0;
    end
    else
    begin
      pll_meta_q <= i_pll_locked;
      pll_sync_q <= pll_meta_q;
    end
  end

  // Wake tracker: clock may be dead right after suspend ends
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wake_q <= uif_pkg::WK_RUN;
      wake_cnt_q <= '0;
    end
    else
    begin
      case (wake_q)
        uif_pkg::WK_RUN:
          if (suspend_q)
            wake_q <= uif_pkg::WK_SUSP;
        uif_pkg::WK_SUSP:
          if (!suspend_q)
            wake_q <= uif_pkg::WK_LOCK;
        uif_pkg::WK_LOCK:
          if (suspend_q)
            wake_q <= uif_pkg::WK_SUSP;
          else if (pll_sync_q)
          begin
            wake_q <= uif_pkg::WK_SYNC;
            wake_cnt_q <= '0;
          end
        uif_pkg::WK_SYNC:
          if (suspend_q)
            wake_q <= uif_pkg::WK_SUSP;
          else if (wake_cnt_q == WAKE_LAST)
            wake_q <= uif_pkg::WK_RUN;
          else
            wake_cnt_q <= wake_cnt_q + WAKE_ONE;
        default:
          wake_q <= uif_pkg::WK_RUN;
      endcase
    end
  end

  // Activity clears are dropped until the wake sequence has finished
  assign clr_block = suspend_q || (wake_q != uif_pkg::WK_RUN);

  // Activity detector arms on bus idle and disarms on first traffic
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      armed_q <= 1'b1;
    else if (idle_pulse)
      armed_q <= 1'b1;
    else if (act_set)
      armed_q <= 1'b0;
  end

  assign act_set = i_bus_traffic && armed_q;

  // Error summary from enabled second-level flags
  assign err_any = |(error_if.flags & error_en_q);

  // Hardware sets for the status level; flags ignore status enables
  always_comb
  begin
    st_hw = i_status_evt & uif_pkg::ST_ENGINE_MASK;
    st_hw[uif_pkg::ST_ERR_BIT] = err_any;
    st_hw[uif_pkg::ST_ACT_BIT] = act_set;
    st_hw[uif_pkg::ST_IDLE_BIT] = idle_pulse;
  end

  // Clear mask hides the activity bit while clears are blocked
  always_comb
  begin
    st_clr_mask = '1;
    st_clr_mask[uif_pkg::ST_ACT_BIT] = !clr_block;
  end

  assign wr_status_clr = i_wr && hit(i_addr, uif_pkg::ADDR_STATUS_FLAGS);

  // Software writes: write one to clear, write one to set
  assign status_if.hw_set = st_hw;
  assign status_if.sw_clr = wr_status_clr ? (i_wdata & st_clr_mask) : '0;
  assign status_if.sw_set =
    (i_wr && hit(i_addr, uif_pkg::ADDR_STATUS_SET)) ? i_wdata : '0;
  assign error_if.hw_set = i_error_evt;
  assign error_if.sw_clr =
    (i_wr && hit(i_addr, uif_pkg::ADDR_ERROR_FLAGS)) ? i_wdata : '0;
  assign error_if.sw_set =
    (i_wr && hit(i_addr, uif_pkg::ADDR_ERROR_SET)) ? i_wdata : '0;

  // Enable registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_en_q <= uif_pkg::RST_BYTE;
      error_en_q <= uif_pkg::RST_BYTE;
    end
    else if (i_wr && hit(i_addr, uif_pkg::ADDR_STATUS_EN))
      status_en_q <= i_wdata;
    else if (i_wr && hit(i_addr, uif_pkg::ADDR_ERROR_EN))
      error_en_q <= i_wdata;
  end

  // Control register; suspend never touches the pull-up
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      suspend_q <= 1'b0;
      pullup_q <= 1'b0;
    end
    else if (i_wr && hit(i_addr, uif_pkg::ADDR_CONTROL))
    begin
      suspend_q <= i_wdata[uif_pkg::CTL_SUSPEND_BIT];
      pullup_q <= i_wdata[uif_pkg::CTL_PULLUP_BIT];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (hit(i_addr, uif_pkg::ADDR_STATUS_FLAGS))
      rdata_d = status_if.flags;
    else if (hit(i_addr, uif_pkg::ADDR_STATUS_SET))
      rdata_d = status_if.flags;
    else if (hit(i_addr, uif_pkg::ADDR_STATUS_EN))
      rdata_d = status_en_q;
    else if (hit(i_addr, uif_pkg::ADDR_ERROR_FLAGS))
      rdata_d = error_if.flags;
    else if (hit(i_addr, uif_pkg::ADDR_ERROR_SET))
      rdata_d = error_if.flags;
    else if (hit(i_addr, uif_pkg::ADDR_ERROR_EN))
      rdata_d = error_en_q;
    else if (hit(i_addr, uif_pkg::ADDR_CONTROL))
    begin
      rdata_d[uif_pkg::CTL_SUSPEND_BIT] = suspend_q;
      rdata_d[uif_pkg::CTL_PULLUP_BIT] = pullup_q;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rdata_q <= '0;
    else if (i_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= '0;
  end

  // Summary request, one register stage after the gating
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      summary_q <= 1'b0;
    else
      summary_q <= |(status_if.flags & status_en_q);
  end

  assign o_rdata = rdata_q;
  assign o_usb_summary_irq_flag = summary_q;
  assign o_suspend_request_bit = suspend_q;
  assign o_pullup_en = pullup_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_blocked_act_clear;
    clr_block && wr_status_clr && i_wdata[uif_pkg::ST_ACT_BIT]
      && status_if.flags[uif_pkg::ST_ACT_BIT];
  endsequence

  sequence s_act_cleared;
    status_if.flags[uif_pkg::ST_ACT_BIT]
      ##1 !status_if.flags[uif_pkg::ST_ACT_BIT] && !armed_q
      && !idle_pulse && !status_if.sw_set[uif_pkg::ST_ACT_BIT];
  endsequence

  sequence s_suspend_exit;
    !suspend_q && (wake_q == uif_pkg::WK_LOCK) && !pll_sync_q;
  endsequence

  AST_SUMMARY_OR: assert property (
    ##1 o_usb_summary_irq_flag == $past(|(status_if.flags & status_en_q)))
    else $error("Summary request does not follow gated flags");

  AST_POLL_WITHOUT_EN: assert property (
    (i_status_evt & uif_pkg::ST_ENGINE_MASK & ~status_en_q) != '0
    |=> (status_if.flags & $past(i_status_evt & uif_pkg::ST_ENGINE_MASK))
        == $past(i_status_evt & uif_pkg::ST_ENGINE_MASK))
    else $error("Disabled status event did not set its flag");

  AST_ERR_SUMMARY: assert property (
    (error_if.flags & error_en_q) != '0
    |=> status_if.flags[uif_pkg::ST_ERR_BIT])
    else $error("Enabled error flag did not raise error summary");

  AST_ERR_IMMEDIATE: assert property (
    i_error_evt != '0 |=> (error_if.flags & $past(i_error_evt))
      == $past(i_error_evt))
    else $error("Error flag not set on the next edge");

  AST_SW_SET: assert property (
    i_wr && hit(i_addr, uif_pkg::ADDR_STATUS_SET)
    |=> (status_if.flags & $past(i_wdata)) == $past(i_wdata))
    else $error("Software set did not take");

  AST_ACT_CLEAR_BLOCKED: assert property (
    s_blocked_act_clear |=> status_if.flags[uif_pkg::ST_ACT_BIT])
    else $error("Activity flag cleared while clears are blocked");

  AST_ACT_ONCE: assert property (
    s_act_cleared |=> !status_if.flags[uif_pkg::ST_ACT_BIT])
    else $error("Activity flag set again without bus idle");

  AST_IDLE_FLAG: assert property (
    idle_pulse |=> status_if.flags[uif_pkg::ST_IDLE_BIT] && armed_q)
    else $error("Bus idle did not set its flag and rearm");

  AST_WAIT_LOCK: assert property (
    s_suspend_exit |=> wake_q != uif_pkg::WK_RUN)
    else $error("Wake sequence ended before clock lock");

  AST_PULLUP_HELD: assert property (
    $rose(suspend_q) |-> $stable(o_pullup_en) ##1 $stable(o_pullup_en))
    else $error("Pull-up changed on entering suspend");

endmodule

`default_nettype wire

// ==== tb/uif_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module uif_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Summary request and firmware clear request
  input wire logic i_irq,
  input wire logic i_fw_clr,
  // Peripheral flag as firmware sees it
  output logic o_core_flag
);
  // A live request wins over the clear, as in the real core, so firmware
  // that clears this before resolving the block's flags gets it back
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_core_flag <= 1'b0;
    end
    else if (i_irq)
    begin
      o_core_flag <= 1'b1;
    end
    else if (i_fw_clr)
    begin
      o_core_flag <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== tb/test_uif_irq_funnel.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_uif_irq_funnel;
  // Short quiet time keeps the run brief
  localparam int unsigned IDLE_N = 20;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [uif_pkg::ADDR_W-1:0] i_addr = 4'h0;
  logic [uif_pkg::DATA_W-1:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_status_evt = 8'h00;
  logic [7:0] i_error_evt = 8'h00;
  logic i_bus_traffic = 1'b0;
  logic i_pll_locked = 1'b1;
  logic fw_clr = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_susp;
  logic o_pullup;
  logic core_flag;
  logic [7:0] rd_val;
  int bad_count = 0;
  int comparisons = 0;

  // 25 MHz clock
  always #20 i_clk = ~i_clk;

  uif_irq_funnel #(.IDLE_CYCLES(IDLE_N)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_status_evt(i_status_evt), .i_error_evt(i_error_evt),
    .i_bus_traffic(i_bus_traffic), .i_pll_locked(i_pll_locked),
    .o_usb_summary_irq_flag(o_irq), .o_suspend_request_bit(o_susp),
    .o_pullup_en(o_pullup)
  );

  uif_core_model core (
    .i_clk(i_clk), .i_rst(i_rst), .i_irq(o_irq), .i_fw_clr(fw_clr),
    .o_core_flag(core_flag)
  );

  // Four-state compare so an unknown never passes
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rc(input string nm, input logic [3:0] a,
    input logic [7:0] m, input logic [7:0] e);
    bus_rd(a, rd_val);
    chk(nm, rd_val & m, e);
  endtask

  task automatic pulse(input logic [7:0] st, input logic [7:0] er);
    @(posedge i_clk);
    i_status_evt <= st;
    i_error_evt <= er;
    @(posedge i_clk);
    i_status_evt <= 8'h00;
    i_error_evt <= 8'h00;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Everything reads zero after reset, unmapped place included
  task automatic t_reset;
    rc("status_flags", uif_pkg::ADDR_STATUS_FLAGS, 8'hFF, 8'h00);
    chk("irq", {7'h00, o_irq}, 8'h00);
    chk("pullup", {7'h00, o_pullup}, 8'h00);
    rc("status_en", uif_pkg::ADDR_STATUS_EN, 8'hFF, 8'h00);
    rc("error_en", uif_pkg::ADDR_ERROR_EN, 8'hFF, 8'h00);
    rc("control", uif_pkg::ADDR_CONTROL, 8'hFF, 8'h00);
    bus_wr(4'hF, 8'hFF);
    rc("unmapped", 4'hF, 8'hFF, 8'h00);
    $display("test reset done");
  endtask

  // Masked event is still latched; enable alone opens the path
  task automatic t_mask;
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'hFF);
    pulse(8'h08, 8'h00);
    idle(3);
    chk("irq masked", {7'h00, o_irq}, 8'h00);
    rc("polled flag", uif_pkg::ADDR_STATUS_FLAGS, 8'h08, 8'h08);
    bus_wr(uif_pkg::ADDR_STATUS_EN, 8'h08);
    idle(2);
    chk("irq enabled", {7'h00, o_irq}, 8'h01);
    idle(1);
    chk("core flag", {7'h00, core_flag}, 8'h01);
    idle(10);
    rc("sticky", uif_pkg::ADDR_STATUS_FLAGS, 8'h08, 8'h08);
    // Read data must fall back to zero once their one cycle is over
    idle(1);
    chk("rdata one cycle", o_rdata, 8'h00);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h08);
    idle(2);
    chk("irq cleared", {7'h00, o_irq}, 8'h00);
    @(posedge i_clk);
    fw_clr <= 1'b1;
    @(posedge i_clk);
    fw_clr <= 1'b0;
    #1;
    chk("core cleared", {7'h00, core_flag}, 8'h00);
    $display("test mask done");
  endtask

  // Second level: only enabled error flags reach the summary bit
  task automatic t_error;
    bus_wr(uif_pkg::ADDR_STATUS_EN, 8'h02);
    bus_wr(uif_pkg::ADDR_ERROR_EN, 8'h01);
    pulse(8'h00, 8'h02);
    rc("err flag", uif_pkg::ADDR_ERROR_FLAGS, 8'hFF, 8'h02);
    rc("err sum off", uif_pkg::ADDR_STATUS_FLAGS, 8'h02, 8'h00);
    chk("irq err off", {7'h00, o_irq}, 8'h00);
    pulse(8'h00, 8'h01);
    idle(3);
    chk("irq err on", {7'h00, o_irq}, 8'h01);
    rc("err sum on", uif_pkg::ADDR_STATUS_FLAGS, 8'h02, 8'h02);
    rc("err both", uif_pkg::ADDR_ERROR_FLAGS, 8'hFF, 8'h03);
    // Error level first, then the summary bit
    bus_wr(uif_pkg::ADDR_ERROR_FLAGS, 8'h03);
    idle(2);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h02);
    idle(2);
    chk("irq err clr", {7'h00, o_irq}, 8'h00);
    rc("err sum clr", uif_pkg::ADDR_STATUS_FLAGS, 8'h02, 8'h00);
    $display("test error done");
  endtask

  // Software set, and a hardware set meeting a clear at one edge
  task automatic t_swset;
    bus_wr(uif_pkg::ADDR_STATUS_EN, 8'h01);
    bus_wr(uif_pkg::ADDR_STATUS_SET, 8'h01);
    rc("sw set", uif_pkg::ADDR_STATUS_FLAGS, 8'h01, 8'h01);
    idle(1);
    chk("irq sw set", {7'h00, o_irq}, 8'h01);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= uif_pkg::ADDR_STATUS_FLAGS;
    i_wdata <= 8'h01;
    i_status_evt <= 8'h01;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_status_evt <= 8'h00;
    rc("set wins", uif_pkg::ADDR_STATUS_FLAGS, 8'h01, 8'h01);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h01);
    rc("clr alone", uif_pkg::ADDR_STATUS_FLAGS, 8'h01, 8'h00);
    bus_wr(uif_pkg::ADDR_ERROR_SET, 8'h80);
    rc("err sw set", uif_pkg::ADDR_ERROR_FLAGS, 8'hFF, 8'h80);
    bus_wr(uif_pkg::ADDR_ERROR_FLAGS, 8'h80);
    $display("test software set done");
  endtask

  // Activity once per resume; idle after the quiet time
  task automatic t_activity;
    @(posedge i_clk);
    i_bus_traffic <= 1'b1;
    rc("act set", uif_pkg::ADDR_STATUS_FLAGS, 8'h04, 8'h04);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h14);
    idle(5);
    rc("act quiet", uif_pkg::ADDR_STATUS_FLAGS, 8'h14, 8'h00);
    @(posedge i_clk);
    i_bus_traffic <= 1'b0;
    idle(IDLE_N - 4);
    rc("idle early", uif_pkg::ADDR_STATUS_FLAGS, 8'h10, 8'h00);
    idle(6);
    rc("idle set", uif_pkg::ADDR_STATUS_FLAGS, 8'h10, 8'h10);
    @(posedge i_clk);
    i_bus_traffic <= 1'b1;
    rc("act again", uif_pkg::ADDR_STATUS_FLAGS, 8'h04, 8'h04);
    $display("test activity done");
  endtask

  // Clears of activity are refused until wake-up has settled
  task automatic t_suspend;
    int n;
    // Pull-up goes on first, once the host powers the bus, then suspend
    bus_wr(uif_pkg::ADDR_CONTROL, 8'h01);
    bus_wr(uif_pkg::ADDR_CONTROL, 8'h03);
    idle(1);
    chk("suspend", {7'h00, o_susp}, 8'h01);
    chk("pullup susp", {7'h00, o_pullup}, 8'h01);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h04);
    rc("act in susp", uif_pkg::ADDR_STATUS_FLAGS, 8'h04, 8'h04);
    @(posedge i_clk);
    i_pll_locked <= 1'b0;
    bus_wr(uif_pkg::ADDR_CONTROL, 8'h01);
    idle(10);
    chk("pullup wake", {7'h00, o_pullup}, 8'h01);
    bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h04);
    rc("act unlocked", uif_pkg::ADDR_STATUS_FLAGS, 8'h04, 8'h04);
    @(posedge i_clk);
    i_pll_locked <= 1'b1;
    // Firmware loop: clear until it reads back zero, with a bound
    for (n = 0; n < 20; n++)
    begin
      bus_rd(uif_pkg::ADDR_STATUS_FLAGS, rd_val);
      if (rd_val[2] !== 1'b1)
        break;
      bus_wr(uif_pkg::ADDR_STATUS_FLAGS, 8'h04);
    end
    chk("act woken", rd_val & 8'h04, 8'h00);
    if (n == 20)
    begin
      bad_count++;
      $display("[ERR] wake loop expected 0 seen timeout");
      final_report();
    end
    $display("test suspend done");
  endtask

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_mask();
    t_error();
    t_swset();
    t_activity();
    t_suspend();
    final_report();
  end
endmodule

`default_nettype wire
